// ==== logic/olsr_pkg.sv ====
// Purpose: Constants and carrier types for the local status register bank
// Assumes: APB with 32-bit data, one register per aligned word
// Notes: Offsets are register indices; byte address is four times the index
`default_nettype none
package olsr_pkg;
  // Register indices and byte addresses
  localparam logic [7:0] IDX_SNAPSHOT = 8'h4F;
  localparam logic [7:0] IDX_STATUS1 = 8'h50;
  localparam logic [7:0] IDX_STATUS2 = 8'h51;
  localparam logic [7:0] IDX_PARTNER1 = 8'h58;
  localparam logic [9:0] ADDR_SNAPSHOT = 10'h13C;
  localparam logic [9:0] ADDR_STATUS1 = 10'h140;
  localparam logic [9:0] ADDR_STATUS2 = 10'h144;
  localparam logic [9:0] ADDR_CONTROL = 10'h180;
  // Field positions, first status register
  localparam int BIT_ROLE = 6;
  localparam int BIT_LOOPBACK = 5;
  localparam int BIT_LOSS_METHOD = 4;
  localparam int BIT_DIAG = 3;
  localparam int BIT_COPPER_DOWN = 2;
  localparam int BIT_OPT_MISSING = 1;
  localparam int BIT_POWER_DOWN = 0;
  // Field positions, second status register and control register
  localparam int BIT_MULTI_IF = 3;
  localparam int BIT_AUTONEG = 2;
  localparam int BIT_CTRL_LINK_SPEED = 0;
  // Reset values
  localparam logic [7:0] RST_SNAP_TERMINAL = 8'h07;
  localparam logic [7:0] RST_SNAP_CENTER = 8'h47;
  localparam logic [7:0] RST_STATUS2 = 8'h00;

  typedef struct packed {
    logic terminal_side_role;
    logic loop_active;
    logic loss_report_pin;
    logic diag_fail_pin;
    logic copper_link_down;
    logic fiber_signal_detect_pin;
    logic power_down_pin_n;
    logic port2_autoneg_strap;
    logic optical_link_up;
    logic warm_reset;
  } olsr_in_t;

  typedef struct packed {
    logic [2:0] sd_sync;
    logic [2:0] pd_sync;
    logic [2:0] diag_sync;
    logic [2:0] loss_sync;
    logic [1:0] boot_q;
    logic snap_hold;
    logic [7:0] snapshot;
    logic [7:0] status1;
    logic [7:0] status2;
    logic link_speed;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } olsr_state_t;
endpackage : olsr_pkg
`default_nettype wire

// ==== logic/olsr_regs.sv ====
// Purpose: Local status register bank with partner-status snapshot, APB slave
// Assumes: pclk 20 MHz; role strap and link state from on-chip logic are stable
// Notes: Signal detect, power-down, diag and loss pins pass three flops; a change counts when stages 2 and 3 agree
// Notes: One wait state on every transfer; read data is caught in the setup phase
// Notes: The snapshot hold survives warm reset and power down, but not presetn
// Notes on behaviour
// - Terminal: snapshot mirrors partner status while link up
// - Center: snapshot loads partner status at link up
// - Center: warm reset or power down keep snapshot; power down does not stop the mirror while link up
// - Center: mirror again once link re-established
// - Snapshot resets 0x07 terminal, 0x47 center
// - Bit 6 shows role, reset by role
// - Bit 5 shows loopback state, resets 0
// - Bit 4 picks loss reporting method
// - Loss bit: host writes center, pin terminal
// - Bit 3 reports diagnostic failure
// - Diag bit: pin on terminal, host on center
// - Bit 2 copper down; center writes, reset 1
// - Bit 1 polled from fiber signal detect
// - Bit 0 inverse of power-down pin
// - Bit 3 multi-interface, center writable only
// - Terminal autoneg bit from strap pin
// - Center autoneg bit reads zero
//
// Decided for this implementation: the APB interface to the registers.
`default_nettype none
module olsr_regs (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire olsr_pkg::olsr_in_t pins,
  input wire logic [7:0] partner_status,
  output logic [7:0] snapshot_bits,
  output logic [7:0] status1_bits,
  output logic [7:0] status2_bits
);
  olsr_pkg::olsr_state_t s_q;
  olsr_pkg::olsr_state_t s_d;
  logic wr_access;
  logic rd_access;
  logic addr_ok;
  logic term;
  // Address decode, shared by the write path, the pslverr response and the checks
  logic hit_sn;
  logic hit_s1;
  logic hit_s2;
  logic hit_ct;
  logic wr_s1;
  logic wr_s2;
  logic wr_ct;

  assign term = pins.terminal_side_role;
  assign hit_sn = paddr == {2'b00, olsr_pkg::ADDR_SNAPSHOT};
  assign hit_s1 = paddr == {2'b00, olsr_pkg::ADDR_STATUS1};
  assign hit_s2 = paddr == {2'b00, olsr_pkg::ADDR_STATUS2};
  assign hit_ct = paddr == {2'b00, olsr_pkg::ADDR_CONTROL};
  assign addr_ok = hit_sn || hit_s1 || hit_s2 || hit_ct;
  assign wr_access = psel && penable && pwrite && !s_q.pready;
  assign rd_access = psel && !penable && !pwrite;
  assign wr_s1 = wr_access && pstrb[0] && hit_s1;
  assign wr_s2 = wr_access && pstrb[0] && hit_s2;
  assign wr_ct = wr_access && pstrb[0] && hit_ct;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.pready = 1'b0;
    s_d.pslverr = 1'b0;
    s_d.sd_sync = {s_q.sd_sync[1:0], pins.fiber_signal_detect_pin};
    s_d.pd_sync = {s_q.pd_sync[1:0], pins.power_down_pin_n};
    s_d.diag_sync = {s_q.diag_sync[1:0], pins.diag_fail_pin};
    s_d.loss_sync = {s_q.loss_sync[1:0], pins.loss_report_pin};

    // ----------------------------------------------------------------
    // Boot capture
    // ----------------------------------------------------------------
    // Straps are caught a few clocks after reset release, never under reset
    if (s_q.boot_q != 2'b11) begin
      s_d.boot_q = s_q.boot_q + 2'b01;
      if (s_q.boot_q == 2'b10) begin
        s_d.status1[olsr_pkg::BIT_ROLE] = term;
        s_d.status2[olsr_pkg::BIT_AUTONEG] = term & pins.port2_autoneg_strap;
        if (term) begin
          s_d.status1[olsr_pkg::BIT_DIAG] = s_q.diag_sync[2];
        end
        if (!s_q.snap_hold) begin
          s_d.snapshot = term ? olsr_pkg::RST_SNAP_TERMINAL : olsr_pkg::RST_SNAP_CENTER;
        end
      end
    end

    // ----------------------------------------------------------------
    // Hardware-owned fields
    // ----------------------------------------------------------------
    s_d.status1[olsr_pkg::BIT_LOOPBACK] = pins.loop_active;
    if (s_q.sd_sync[2] == s_q.sd_sync[1]) begin
      s_d.status1[olsr_pkg::BIT_OPT_MISSING] = !s_q.sd_sync[2];
    end
    if (s_q.pd_sync[2] == s_q.pd_sync[1]) begin
      s_d.status1[olsr_pkg::BIT_POWER_DOWN] = !s_q.pd_sync[2];
    end
    if (term) begin
      if (s_q.diag_sync[2] == s_q.diag_sync[1]) begin
        s_d.status1[olsr_pkg::BIT_DIAG] = s_q.diag_sync[2];
      end
      if (s_q.loss_sync[2] == s_q.loss_sync[1]) begin
        s_d.status1[olsr_pkg::BIT_LOSS_METHOD] = s_q.loss_sync[2];
      end
      s_d.status1[olsr_pkg::BIT_COPPER_DOWN] = pins.copper_link_down;
      s_d.status2[olsr_pkg::BIT_MULTI_IF] = 1'b0;
      s_d.status2[olsr_pkg::BIT_AUTONEG] = pins.port2_autoneg_strap;
    end else begin
      s_d.status2[olsr_pkg::BIT_AUTONEG] = 1'b0;
    end
    s_d.status1[7] = s_q.link_speed;

    // ----------------------------------------------------------------
    // Snapshot: held through warm reset; power down on the center side only sets the hold flag
    // ----------------------------------------------------------------
    if (!term && (pins.warm_reset || s_q.status1[olsr_pkg::BIT_POWER_DOWN])) begin
      s_d.snap_hold = 1'b1;
    end
    if (pins.optical_link_up && !pins.warm_reset) begin
      s_d.snapshot = partner_status;
      s_d.snap_hold = 1'b0;
    end

    // ----------------------------------------------------------------
    // APB write, takes effect in the access phase
    // ----------------------------------------------------------------
    if (wr_access && pstrb[0]) begin
      if (hit_s1 && !term) begin
        s_d.status1[olsr_pkg::BIT_LOSS_METHOD] = pwdata[olsr_pkg::BIT_LOSS_METHOD];
        s_d.status1[olsr_pkg::BIT_DIAG] = pwdata[olsr_pkg::BIT_DIAG];
        s_d.status1[olsr_pkg::BIT_COPPER_DOWN] = pwdata[olsr_pkg::BIT_COPPER_DOWN];
      end
      if (hit_s2 && !term) begin
        // Reserved upper bits stay zero whatever software writes
        s_d.status2[olsr_pkg::BIT_MULTI_IF] = pwdata[olsr_pkg::BIT_MULTI_IF];
      end
      if (hit_ct) begin
        s_d.link_speed = pwdata[olsr_pkg::BIT_CTRL_LINK_SPEED];
      end
    end
    if (psel && penable && !s_q.pready) begin
      s_d.pready = 1'b1;
      s_d.pslverr = !addr_ok;
    end

    // ----------------------------------------------------------------
    // Read data sampled in setup, presented with pready
    // ----------------------------------------------------------------
    // Catching in setup keeps the mux off the pready path at the cost of
    // data that is one cycle older than the access phase
    if (rd_access) begin
      s_d.prdata = 32'h0000_0000;
      unique case (paddr)
        {2'b00, olsr_pkg::ADDR_SNAPSHOT}: s_d.prdata[7:0] = s_q.snapshot;
        {2'b00, olsr_pkg::ADDR_STATUS1}: s_d.prdata[7:0] = s_q.status1;
        {2'b00, olsr_pkg::ADDR_STATUS2}: s_d.prdata[7:0] = s_q.status2;
        {2'b00, olsr_pkg::ADDR_CONTROL}: s_d.prdata[0] = s_q.link_speed;
        default: s_d.prdata = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      // Role unknown until strap is caught; center value is the safe default
      s_q.snapshot <= olsr_pkg::RST_SNAP_CENTER;
      s_q.status1 <= 8'h04;
      s_q.status2 <= olsr_pkg::RST_STATUS2;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign snapshot_bits = s_q.snapshot;
  assign status1_bits = s_q.status1;
  assign status2_bits = s_q.status2;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence link_held;
    pins.optical_link_up && !pins.warm_reset;
  endsequence

  sequence apb_setup;
    psel && !penable;
  endsequence

  sequence apb_access;
    psel && penable && !pready;
  endsequence

  a_snap_mirror: assert property (@(posedge pclk) disable iff (!presetn)
    link_held |=> snapshot_bits == $past(partner_status))
    else $error("snapshot does not follow partner status");
  a_snap_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (!term && !pins.optical_link_up && s_q.boot_q == 2'b11) |=> $stable(snapshot_bits))
    else $error("snapshot changed while link down");
  a_role_bit: assert property (@(posedge pclk) disable iff (!presetn)
    s_q.boot_q == 2'b11 && $stable(term) |=> status1_bits[6] == $past(status1_bits[6]))
    else $error("role bit moved");
  a_loop_bit: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> status1_bits[5] == $past(pins.loop_active))
    else $error("loopback bit wrong");
  a_sd_bit: assert property (@(posedge pclk) disable iff (!presetn)
    s_q.sd_sync[2] == s_q.sd_sync[1] |=> status1_bits[1] == !$past(s_q.sd_sync[2]))
    else $error("signal detect bit wrong");
  a_pd_bit: assert property (@(posedge pclk) disable iff (!presetn)
    s_q.pd_sync[2] == s_q.pd_sync[1] |=> status1_bits[0] == !$past(s_q.pd_sync[2]))
    else $error("power down bit wrong");
  a_upper_zero: assert property (@(posedge pclk) disable iff (!presetn)
    status2_bits[7:4] == 4'h0)
    else $error("reserved bits set");
  a_center_an: assert property (@(posedge pclk) disable iff (!presetn)
    !term ##1 !term |-> status2_bits[2] == 1'b0)
    else $error("center autoneg bit set");
  a_term_multi: assert property (@(posedge pclk) disable iff (!presetn)
    term ##1 term |-> status2_bits[3] == 1'b0)
    else $error("terminal multi-interface bit set");
  a_term_diag: assert property (@(posedge pclk) disable iff (!presetn)
    term && s_q.diag_sync[2] == s_q.diag_sync[1] |=> status1_bits[3] == $past(s_q.diag_sync[2]))
    else $error("diag bit not from pin");

  // ----------------------------------------------------------------
  // Bus handshake, read data and control register checks
  // ----------------------------------------------------------------
  a_pready_pulse: assert property (
    @(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("pready held longer than one cycle");
  a_pready_answer: assert property (
    @(posedge pclk) disable iff (!presetn)
    apb_access |=> pready)
    else $error("no answer after access phase");
  a_transfer_steps: assert property (
    @(posedge pclk) disable iff (!presetn)
    apb_setup ##1 apb_access |=> pready)
    else $error("transfer did not complete with one wait state");
  a_pready_cause: assert property (
    @(posedge pclk) disable iff (!presetn)
    pready |-> $past(psel && penable))
    else $error("pready without access phase");
  a_err_unmapped: assert property (
    @(posedge pclk) disable iff (!presetn)
    apb_access and !addr_ok |=> pslverr)
    else $error("unmapped access not flagged");
  a_err_mapped: assert property (
    @(posedge pclk) disable iff (!presetn)
    psel && penable && !pready && addr_ok |=> !pslverr)
    else $error("mapped access flagged");
  a_err_with_ready: assert property (
    @(posedge pclk) disable iff (!presetn)
    pslverr |-> pready)
    else $error("pslverr without pready");
  a_rd_upper: assert property (
    @(posedge pclk) disable iff (!presetn)
    prdata[31:8] == 24'h00_0000)
    else $error("read data upper bits set");
  a_rd_snap: assert property (
    @(posedge pclk) disable iff (!presetn)
    rd_access && hit_sn |=> prdata[7:0] == $past(snapshot_bits))
    else $error("snapshot read data wrong");
  a_rd_first: assert property (
    @(posedge pclk) disable iff (!presetn)
    rd_access && hit_s1 |=> prdata[7:0] == $past(status1_bits))
    else $error("first status read data wrong");
  a_rd_second: assert property (
    @(posedge pclk) disable iff (!presetn)
    rd_access && hit_s2 |=> prdata[7:0] == $past(status2_bits))
    else $error("second status read data wrong");
  a_rd_unmapped: assert property (
    @(posedge pclk) disable iff (!presetn)
    rd_access && !addr_ok |=> prdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_ctrl_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_ct |=> s_q.link_speed == $past(pwdata[0]))
    else $error("control write lost");
  a_speed_bit: assert property (
    @(posedge pclk) disable iff (!presetn)
    1'b1 |=> status1_bits[7] == $past(s_q.link_speed))
    else $error("link speed bit wrong");

  // ----------------------------------------------------------------
  // Boot capture checks
  // ----------------------------------------------------------------
  a_boot_stop: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_q.boot_q == 2'b11 |=> s_q.boot_q == 2'b11)
    else $error("boot counter moved after capture");
  a_boot_role: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_q.boot_q == 2'b10 |=> status1_bits[6] == $past(term))
    else $error("role bit not captured");
  a_boot_snap: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_q.boot_q == 2'b10 && !s_q.snap_hold && !(pins.optical_link_up && !pins.warm_reset)
    |=> snapshot_bits == ($past(term) ? olsr_pkg::RST_SNAP_TERMINAL : olsr_pkg::RST_SNAP_CENTER))
    else $error("snapshot reset value wrong");
  a_boot_diag: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_q.boot_q == 2'b10 && term |=> status1_bits[3] == $past(s_q.diag_sync[2]))
    else $error("diag bit not captured at boot");

  // ----------------------------------------------------------------
  // Snapshot checks
  // ----------------------------------------------------------------
  a_snap_warm: assert property (
    @(posedge pclk) disable iff (!presetn)
    pins.warm_reset && s_q.boot_q == 2'b11 |=> $stable(snapshot_bits))
    else $error("snapshot written during warm reset");
  a_snap_term_down: assert property (
    @(posedge pclk) disable iff (!presetn)
    term && !pins.optical_link_up && s_q.boot_q == 2'b11 |=> $stable(snapshot_bits))
    else $error("terminal snapshot moved while link down");
  a_hold_set: assert property (
    @(posedge pclk) disable iff (!presetn)
    !term && pins.warm_reset |=> s_q.snap_hold)
    else $error("snapshot hold not set");
  a_hold_clear: assert property (
    @(posedge pclk) disable iff (!presetn)
    link_held |=> !s_q.snap_hold)
    else $error("snapshot hold not cleared");

  // ----------------------------------------------------------------
  // Field ownership checks
  // ----------------------------------------------------------------
  a_term_loss: assert property (
    @(posedge pclk) disable iff (!presetn)
    term && s_q.loss_sync[2] == s_q.loss_sync[1] |=> status1_bits[4] == $past(s_q.loss_sync[2]))
    else $error("loss bit not from pin");
  a_term_copper: assert property (
    @(posedge pclk) disable iff (!presetn)
    term |=> status1_bits[2] == $past(pins.copper_link_down))
    else $error("copper bit not from hardware");
  a_term_an: assert property (
    @(posedge pclk) disable iff (!presetn)
    term |=> status2_bits[2] == $past(pins.port2_autoneg_strap))
    else $error("autoneg bit not from strap");
  a_center_loss: assert property (
    @(posedge pclk) disable iff (!presetn)
    !term && wr_s1 |=> status1_bits[4] == $past(pwdata[4]))
    else $error("center loss write lost");
  a_center_diag: assert property (
    @(posedge pclk) disable iff (!presetn)
    !term && wr_s1 |=> status1_bits[3] == $past(pwdata[3]))
    else $error("center diag write lost");
  a_center_copper: assert property (
    @(posedge pclk) disable iff (!presetn)
    !term && wr_s1 |=> status1_bits[2] == $past(pwdata[2]))
    else $error("center copper write lost");
  a_center_keep: assert property (
    @(posedge pclk) disable iff (!presetn)
    !term && !wr_s1 |=> $stable(status1_bits[4:2]))
    else $error("center status bits moved without write");
  a_multi_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    !term && wr_s2 |=> status2_bits[3] == $past(pwdata[3]))
    else $error("multi-interface write lost");
  a_multi_keep: assert property (
    @(posedge pclk) disable iff (!presetn)
    !term && !wr_s2 |=> $stable(status2_bits[3]))
    else $error("multi-interface bit moved without write");
endmodule : olsr_regs
`default_nettype wire

// ==== tb/olsr_partner_model.sv ====
// Purpose: Remote converter model driving partner status and optical link state
// Assumes: the bench commands link state and the status value
// Notes: status is not held while the link is down
`default_nettype none
module olsr_partner_model (
  input wire logic pclk,
  input wire logic link_cmd,
  input wire logic [7:0] status_cmd,
  output logic optical_link_up,
  output logic [7:0] partner_status
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------
  // Link and status
  // ------------------------------
  initial optical_link_up = 1'b0;
  initial partner_status = 8'h00;
  // Status is stale without a link; toggling it exposes a bank that keeps sampling
  always @(posedge pclk) begin
    optical_link_up <= link_cmd;
    partner_status <= link_cmd ? status_cmd : ~partner_status;
  end
endmodule : olsr_partner_model
`default_nettype wire

// ==== tb/olsr_regs_tb.sv ====
// Purpose: Self-checking bench for the local status register bank
// Assumes: pin changes settle within eight cycles
// Notes: role changes only under reset
`default_nettype none
module olsr_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] A_SN = {2'h0, olsr_pkg::ADDR_SNAPSHOT};
  localparam logic [11:0] A_S1 = {2'h0, olsr_pkg::ADDR_STATUS1};
  localparam logic [11:0] A_S2 = {2'h0, olsr_pkg::ADDR_STATUS2};
  localparam logic [11:0] A_CT = {2'h0, olsr_pkg::ADDR_CONTROL};
  logic [7:0] snap_o;
  logic [7:0] s1_o;
  logic [7:0] s2_o;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic link_cmd = 1'b0;
  logic link_up;
  logic [7:0] st_cmd = 8'h00;
  logic [7:0] pstat;
  olsr_pkg::olsr_in_t pv = '0;
  olsr_pkg::olsr_in_t pins;
  int failures = 0;
  int check_count = 0;
  int cyc = 0;
  always #25 pclk = ~pclk;
  always_comb begin
    pins = pv;
    pins.optical_link_up = link_up;
  end
  olsr_partner_model PM (.pclk(pclk), .link_cmd(link_cmd), .status_cmd(st_cmd),
    .optical_link_up(link_up), .partner_status(pstat));
  olsr_regs DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pins(pins), .partner_status(pstat),
    .snapshot_bits(snap_o), .status1_bits(s1_o), .status2_bits(s2_o));
  // ------------------------------
  // Bus and check tasks
  // ------------------------------
  task automatic finish_test;
    $display("checks=%0d failures=%0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : finish_test
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      finish_test();
    end
  end
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d, output logic [32:0] r);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
    if (n >= 20) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, pready, 1'b1);
    end
    r = {pslverr, prdata};
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic err = 1'b0);
    logic [32:0] r;
    apb(1'b0, a, 8'h00, r);
    check_count++;
    if (r !== {err, 24'h0, e}) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, r, {err, 24'h0, e});
    end
  endtask : rd
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [32:0] r;
    apb(1'b1, a, d, r);
  endtask : wr
  task automatic settle;
    repeat (8) @(posedge pclk);
  endtask : settle
  task automatic start(input logic role);
    olsr_pkg::olsr_in_t v;
    v = '0;
    v.power_down_pin_n = 1'b1;
    v.fiber_signal_detect_pin = 1'b1;
    v.port2_autoneg_strap = 1'b1;
    v.terminal_side_role = role;
    pv <= v;
    link_cmd <= 1'b0;
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
  endtask : start
  // ------------------------------
  // Scenarios
  // ------------------------------
  task automatic t_term;
    start(1'b1);
    rd(A_SN, olsr_pkg::RST_SNAP_TERMINAL);
    rd(A_S1, 8'h40);
    rd(A_S2, 8'h04);
    st_cmd <= 8'h5A;
    link_cmd <= 1'b1;
    settle();
    rd(A_SN, 8'h5A);
    st_cmd <= 8'hA5;
    settle();
    rd(A_SN, 8'hA5);
    pv.loop_active <= 1'b1;
    pv.loss_report_pin <= 1'b1;
    pv.diag_fail_pin <= 1'b1;
    pv.copper_link_down <= 1'b1;
    pv.fiber_signal_detect_pin <= 1'b0;
    pv.power_down_pin_n <= 1'b0;
    settle();
    wr(A_S1, 8'h00);
    rd(A_S1, 8'h7F);
    chk(s1_o, 8'h7F);
    wr(A_S2, 8'h08);
    rd(A_S2, 8'h04);
    chk(s2_o, 8'h04);
  endtask : t_term
  task automatic t_cent;
    start(1'b0);
    rd(A_SN, olsr_pkg::RST_SNAP_CENTER);
    rd(A_S1, 8'h04);
    rd(A_S2, 8'h00);
    st_cmd <= 8'h33;
    link_cmd <= 1'b1;
    settle();
    rd(A_SN, 8'h33);
    link_cmd <= 1'b0;
    settle();
    pv.warm_reset <= 1'b1;
    settle();
    pv.warm_reset <= 1'b0;
    st_cmd <= 8'h11;
    settle();
    rd(A_SN, 8'h33);
    link_cmd <= 1'b1;
    settle();
    rd(A_SN, 8'h11);
    chk(snap_o, 8'h11);
    link_cmd <= 1'b0;
    pv.power_down_pin_n <= 1'b0;
    st_cmd <= 8'h22;
    settle();
    rd(A_SN, 8'h11);
    pv.power_down_pin_n <= 1'b1;
    link_cmd <= 1'b1;
    settle();
    rd(A_SN, 8'h22);
    wr(A_S1, 8'hFC);
    pv.loop_active <= 1'b1;
    settle();
    rd(A_S1, 8'h3C);
    wr(A_S2, 8'h0F);
    rd(A_S2, 8'h08);
    wr(A_CT, 8'h01);
    rd(A_CT, 8'h01);
    rd(A_S1, 8'hBC);
    rd(12'h200, 8'h00, 1'b1);
  endtask : t_cent
  initial begin
    t_term();
    t_cent();
    finish_test();
  end
endmodule : olsr_regs_tb
`default_nettype wire
